// ==== logic/abte_core.sv ====
// Wishbone-driven execute core for add, and, bit clear/set and bit-test-skip
`timescale 1ns/1ns
`default_nettype none

module abte_core (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [abte_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic [7:0] W_OUT,
  output logic SKIP_OUT
);

  logic [7:0] w;
  logic c_flag;
  logic nibble_carry_flag;
  logic z_flag;
  logic skip_pend;
  logic [13:0] last_instr;
  logic [15:0] cyc_cnt;
  logic [7:0] file_mem [abte_pkg::FILE_DEPTH];
  logic ack;
  logic [31:0] rdat;

  // Bus decode
  wire req = WB_CYC_IN & WB_STB_IN;
  wire commit = req & ack;
  wire wr = commit & WB_WE_IN;
  wire next_ack = req & !ack;
  wire lane0 = (WB_SEL_IN & abte_pkg::SEL_BYTE) == abte_pkg::SEL_BYTE;
  wire lanes_instr = (WB_SEL_IN & abte_pkg::SEL_INSTR) == abte_pkg::SEL_INSTR;
  wire hit_instr = WB_ADR_IN == abte_pkg::ADR_INSTR;
  wire hit_wreg = WB_ADR_IN == abte_pkg::ADR_WREG;
  wire hit_stat = WB_ADR_IN == abte_pkg::ADR_STAT;
  wire hit_cyc = WB_ADR_IN == abte_pkg::ADR_CYCLES;
  wire hit_file = (WB_ADR_IN & abte_pkg::ADR_FILE_MASK) == abte_pkg::ADR_FILE_BASE;
  wire [6:0] bus_idx = WB_ADR_IN[abte_pkg::FILE_IDX_LSB +: abte_pkg::FADDR_W];

  // A write to the instruction word with byte lanes 0 and 1 selected is one instruction cycle
  wire wr_instr = wr & hit_instr & lanes_instr;
  wire exec = wr_instr & !skip_pend;
  wire discard = wr_instr & skip_pend;
  wire wr_wreg = wr & hit_wreg & lane0;
  wire wr_stat = wr & hit_stat & lane0;
  wire wr_file = wr & hit_file & lane0;

  // Instruction fields
  wire [13:0] instr = WB_DAT_IN[abte_pkg::INSTR_W-1:0];
  abte_pkg::abte_file_ins_t f_ins;
  abte_pkg::abte_bit_ins_t b_ins;
  abte_pkg::abte_lit_ins_t l_ins;
  assign f_ins = abte_pkg::abte_file_ins_t'(instr);
  assign b_ins = abte_pkg::abte_bit_ins_t'(instr);
  assign l_ins = abte_pkg::abte_lit_ins_t'(instr);

  wire [6:0] faddr = f_ins.faddr;
  wire [7:0] lit_k = l_ins.lit;
  wire [2:0] bitn = b_ins.bitn;
  wire [7:0] fval = file_mem[faddr];

  abte_pkg::abte_op_t op;
  assign op = (l_ins.opc[5:1] == abte_pkg::OPC_ADD_IMM) ? abte_pkg::OP_ADD_IMM :
              (l_ins.opc == abte_pkg::OPC_AND_IMM) ? abte_pkg::OP_AND_IMM :
              (f_ins.opc == abte_pkg::OPC_ADD_FILE) ? abte_pkg::OP_ADD_FILE :
              (f_ins.opc == abte_pkg::OPC_AND_FILE) ? abte_pkg::OP_AND_FILE :
              (b_ins.opc == abte_pkg::OPC_BIT_CLR) ? abte_pkg::OP_BIT_CLR :
              (b_ins.opc == abte_pkg::OPC_BIT_SET) ? abte_pkg::OP_BIT_SET :
              (b_ins.opc == abte_pkg::OPC_TST_LOW) ? abte_pkg::OP_TST_LOW :
              (b_ins.opc == abte_pkg::OPC_TST_HIGH) ? abte_pkg::OP_TST_HIGH :
              abte_pkg::OP_NONE;

  abte_pkg::abte_alu_req_t alu_req;
  abte_pkg::abte_alu_res_t alu_res;
  assign alu_req.op = op;
  assign alu_req.w = w;
  assign alu_req.fval = fval;
  assign alu_req.lit = lit_k;
  assign alu_req.bitn = bitn;
  assign alu_req.dest = f_ins.dest;

  abte_alu u_alu (
    .req_in(alu_req),
    .res_out(alu_res)
  );

  // Next state
  wire ex_w = exec & alu_res.wr_w;
  wire ex_f = exec & alu_res.wr_f;
  wire ex_arith = exec & alu_res.upd_arith;
  wire ex_z = exec & alu_res.upd_z;

  wire [7:0] next_w = ex_w ? alu_res.value :
                      wr_wreg ? WB_DAT_IN[abte_pkg::DATA_W-1:0] : w;
  wire next_c = ex_arith ? alu_res.c :
                wr_stat ? WB_DAT_IN[0] : c_flag;
  wire next_dc = ex_arith ? alu_res.dc :
                 wr_stat ? WB_DAT_IN[1] : nibble_carry_flag;
  wire next_z = ex_z ? alu_res.z :
                wr_stat ? WB_DAT_IN[2] : z_flag;
  // Only an executed test can arm a skip, so set and clear never meet
  wire next_skip = exec ? alu_res.skip :
                   discard ? 1'b0 : skip_pend;
  wire [13:0] next_last = discard ? abte_pkg::NOP_WORD : instr;

  wire mem_we = ex_f | wr_file;
  wire [6:0] mem_wa = ex_f ? faddr : bus_idx;
  wire [7:0] mem_wd = ex_f ? alu_res.value : WB_DAT_IN[abte_pkg::DATA_W-1:0];

  // Read selection
  wire [3:0] stat_word = {skip_pend, z_flag, nibble_carry_flag, c_flag};
  wire [31:0] rd_mux =
    hit_instr ? {{(32-abte_pkg::INSTR_W){1'b0}}, last_instr} :
    hit_wreg ? {{(32-abte_pkg::DATA_W){1'b0}}, w} :
    hit_stat ? {{(32-abte_pkg::STAT_W){1'b0}}, stat_word} :
    hit_cyc ? {{(32-abte_pkg::CYC_W){1'b0}}, cyc_cnt} :
    hit_file ? {{(32-abte_pkg::DATA_W){1'b0}}, file_mem[bus_idx]} :
    abte_pkg::RD_ZERO;

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ack <= 1'b0;
      rdat <= abte_pkg::RD_ZERO;
    end else begin
      ack <= next_ack;
      rdat <= next_ack ? rd_mux : abte_pkg::RD_ZERO;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      w <= abte_pkg::W_RST;
      c_flag <= abte_pkg::FLAG_RST;
      nibble_carry_flag <= abte_pkg::FLAG_RST;
      z_flag <= abte_pkg::FLAG_RST;
      skip_pend <= abte_pkg::FLAG_RST;
    end else begin
      w <= next_w;
      c_flag <= next_c;
      nibble_carry_flag <= next_dc;
      z_flag <= next_z;
      skip_pend <= next_skip;
    end
  end

  // The discarded word still costs a cycle, so a taken skip counts two
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cyc_cnt <= abte_pkg::CYC_RST;
      last_instr <= abte_pkg::INSTR_RST;
    end else if (wr_instr) begin
      cyc_cnt <= cyc_cnt + abte_pkg::CYC_ONE;
      last_instr <= next_last;
    end
  end

  // Execute and bus writes share one write port: the bit ops rewrite all eight bits
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < abte_pkg::FILE_DEPTH; i++) begin
        file_mem[i] <= abte_pkg::FILE_RST;
      end
    end else if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  assign WB_ACK_OUT = ack;
  assign WB_DAT_OUT = rdat;
  assign W_OUT = w;
  assign SKIP_OUT = skip_pend;

  // Checks
  wire [4:0] chk_nib = {1'b0, w[3:0]} + {1'b0, lit_k[3:0]};
  wire [8:0] chk_sum = {1'b0, w} + {1'b0, lit_k};
  wire [7:0] chk_mask = 8'h01 << bitn;

  add_imm_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_ADD_IMM |=> w == 8'($past(w) + $past(lit_k)))
    else $error("add immediate result wrong");

  add_file_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_ADD_FILE && !f_ins.dest
    |=> w == 8'($past(w) + $past(fval)) && z_flag == (w == 8'h00))
    else $error("add file result wrong");

  dest_file_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_ADD_FILE && f_ins.dest
    |=> $stable(w) && file_mem[$past(faddr)] == 8'($past(w) + $past(fval)))
    else $error("destination select wrong");

  and_imm_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_AND_IMM
    |=> w == ($past(w) & $past(lit_k)) && $stable(c_flag) && $stable(nibble_carry_flag))
    else $error("and immediate wrong");

  and_file_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_AND_FILE
    |=> z_flag == (($past(w) & $past(fval)) == 8'h00) && $stable(c_flag))
    else $error("and file flags wrong");

  bit_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_BIT_CLR
    |=> file_mem[$past(faddr)] == ($past(fval) & ~$past(chk_mask)) && $stable(z_flag))
    else $error("bit clear wrong");

  bit_set_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_BIT_SET
    |=> file_mem[$past(faddr)] == ($past(fval) | $past(chk_mask)) && $stable(c_flag))
    else $error("bit set wrong");

  skip_low_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_TST_LOW |=> skip_pend == !$past(fval[bitn]))
    else $error("skip if low wrong");

  skip_high_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_TST_HIGH |=> skip_pend == $past(fval[bitn]))
    else $error("skip if high wrong");

  skip_discard_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    discard |=> !skip_pend && $stable(w) && $stable(z_flag) && last_instr == abte_pkg::NOP_WORD)
    else $error("discarded word had effect");

  carry_flags_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_ADD_IMM
    |=> c_flag == $past(chk_sum[8]) && nibble_carry_flag == $past(chk_nib[4]))
    else $error("carry flags wrong");

  rmw_one_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && (op == abte_pkg::OP_BIT_SET || op == abte_pkg::OP_BIT_CLR)
    |=> (file_mem[$past(faddr)] & ~$past(chk_mask)) == ($past(fval) & ~$past(chk_mask)))
    else $error("other bits disturbed");

  ack_pulse_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    req && !ack |=> ack ##1 !ack)
    else $error("ack not a single pulse");

  and_file_w_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_AND_FILE && !f_ins.dest
    |=> w == ($past(w) & $past(fval)) && $stable(nibble_carry_flag))
    else $error("and file to w wrong");

  and_dest_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_AND_FILE && f_ins.dest
    |=> $stable(w) && file_mem[$past(faddr)] == ($past(w) & $past(fval)))
    else $error("and file destination wrong");

  add_zero_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && op == abte_pkg::OP_ADD_IMM
    |=> z_flag == (w == '0))
    else $error("zero flag wrong after add");

  bit_flags_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && (op == abte_pkg::OP_BIT_CLR || op == abte_pkg::OP_BIT_SET)
    |=> $stable(c_flag) && $stable(nibble_carry_flag) && $stable(z_flag) && $stable(w))
    else $error("bit op touched flags or w");

  test_quiet_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    exec && (op == abte_pkg::OP_TST_LOW || op == abte_pkg::OP_TST_HIGH)
    |=> $stable(w) && $stable(c_flag) && $stable(z_flag) && $stable(nibble_carry_flag))
    else $error("bit test changed state");

  discard_file_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    discard
    |=> file_mem[$past(faddr)] == $past(fval) && $stable(c_flag))
    else $error("discarded word wrote a file register");

  cycle_step_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    wr_instr
    |=> cyc_cnt == $past(cyc_cnt) + abte_pkg::CYC_ONE)
    else $error("cycle count did not step");

  w_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    !exec && !wr_wreg
    |=> $stable(w))
    else $error("w changed without a cause");

  flags_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    !exec && !wr_stat
    |=> $stable(c_flag) && $stable(nibble_carry_flag) && $stable(z_flag))
    else $error("flags changed without a cause");

  read_wreg_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    ack && !WB_WE_IN && hit_wreg
    |-> WB_DAT_OUT == {{(32-abte_pkg::DATA_W){1'b0}}, w})
    else $error("w read back wrong");

  skip_hold_a: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
    skip_pend && !wr_instr
    |=> skip_pend)
    else $error("armed skip lost");

endmodule : abte_core

`default_nettype wire

// ==== logic/abte_pkg.sv ====
// Constants, opcode fields and carrier types for the add and bit-test execute block
package abte_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned CYC_W = 16;
  localparam int unsigned ADR_W = 10;
  localparam int unsigned FILE_IDX_LSB = 2;
  localparam int unsigned STAT_W = 4;

  // Register map, byte addresses of aligned 32-bit words
  localparam logic [9:0] ADR_INSTR = 10'h000;
  localparam logic [9:0] ADR_WREG = 10'h004;
  localparam logic [9:0] ADR_STAT = 10'h008;
  localparam logic [9:0] ADR_CYCLES = 10'h00c;
  localparam logic [9:0] ADR_FILE_BASE = 10'h200;
  localparam logic [9:0] ADR_FILE_MASK = 10'h203;

  localparam logic [3:0] SEL_INSTR = 4'h3;
  localparam logic [3:0] SEL_BYTE = 4'h1;

  // Reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [15:0] CYC_RST = 16'h0000;
  localparam logic [15:0] CYC_ONE = 16'h0001;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Opcode fields
  localparam logic [4:0] OPC_ADD_IMM = 5'h1f;
  localparam logic [5:0] OPC_AND_IMM = 6'h39;
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [3:0] OPC_BIT_CLR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_TST_LOW = 4'h6;
  localparam logic [3:0] OPC_TST_HIGH = 4'h7;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;

  typedef enum logic [8:0] {
    OP_NONE = 9'h001,
    OP_ADD_IMM = 9'h002,
    OP_ADD_FILE = 9'h004,
    OP_AND_IMM = 9'h008,
    OP_AND_FILE = 9'h010,
    OP_BIT_CLR = 9'h020,
    OP_BIT_SET = 9'h040,
    OP_TST_LOW = 9'h080,
    OP_TST_HIGH = 9'h100
  } abte_op_t;

  typedef struct packed {
    logic [5:0] opc;
    logic dest;
    logic [6:0] faddr;
  } abte_file_ins_t;

  typedef struct packed {
    logic [3:0] opc;
    logic [2:0] bitn;
    logic [6:0] faddr;
  } abte_bit_ins_t;

  typedef struct packed {
    logic [5:0] opc;
    logic [7:0] lit;
  } abte_lit_ins_t;

  typedef struct packed {
    abte_op_t op;
    logic [7:0] w;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [2:0] bitn;
    logic dest;
  } abte_alu_req_t;

  typedef struct packed {
    logic [7:0] value;
    logic c;
    logic dc;
    logic z;
    logic wr_w;
    logic wr_f;
    logic upd_arith;
    logic upd_z;
    logic skip;
  } abte_alu_res_t;

endpackage : abte_pkg

// ==== logic/abte_alu.sv ====
// Combinational execute unit: add, and, bit clear/set and bit test
`timescale 1ns/1ns
`default_nettype none

module abte_alu (
  input wire abte_pkg::abte_alu_req_t req_in,
  output abte_pkg::abte_alu_res_t res_out
);

  logic [7:0] opnd;
  logic [8:0] add_sum;
  logic [4:0] nib_sum;
  logic [7:0] bit_mask;
  logic bit_val;
  logic lit_form;

  assign lit_form = (req_in.op == abte_pkg::OP_ADD_IMM) || (req_in.op == abte_pkg::OP_AND_IMM);
  assign opnd = lit_form ? req_in.lit : req_in.fval;
  assign add_sum = {1'b0, req_in.w} + {1'b0, opnd};
  assign nib_sum = {1'b0, req_in.w[abte_pkg::NIB_W-1:0]} + {1'b0, opnd[abte_pkg::NIB_W-1:0]};

  genvar i;
  generate
    for (i = 0; i < abte_pkg::DATA_W; i++) begin : g_mask
      assign bit_mask[i] = (req_in.bitn == 3'(i));
    end
  endgenerate

  assign bit_val = |(req_in.fval & bit_mask);

  always_comb begin
    res_out = '0;
    case (req_in.op)
      abte_pkg::OP_ADD_IMM, abte_pkg::OP_ADD_FILE: begin
        res_out.value = add_sum[abte_pkg::DATA_W-1:0];
        res_out.c = add_sum[abte_pkg::DATA_W];
        res_out.dc = nib_sum[abte_pkg::NIB_W];
        res_out.z = (add_sum[abte_pkg::DATA_W-1:0] == abte_pkg::W_RST);
        res_out.upd_arith = 1'b1;
        res_out.upd_z = 1'b1;
        res_out.wr_w = lit_form || (req_in.dest == abte_pkg::DEST_W);
        res_out.wr_f = !lit_form && (req_in.dest == abte_pkg::DEST_F);
      end
      abte_pkg::OP_AND_IMM, abte_pkg::OP_AND_FILE: begin
        res_out.value = req_in.w & opnd;
        res_out.z = ((req_in.w & opnd) == abte_pkg::W_RST);
        res_out.upd_z = 1'b1;
        res_out.wr_w = lit_form || (req_in.dest == abte_pkg::DEST_W);
        res_out.wr_f = !lit_form && (req_in.dest == abte_pkg::DEST_F);
      end
      abte_pkg::OP_BIT_CLR: begin
        res_out.value = req_in.fval & ~bit_mask;
        res_out.wr_f = 1'b1;
      end
      abte_pkg::OP_BIT_SET: begin
        res_out.value = req_in.fval | bit_mask;
        res_out.wr_f = 1'b1;
      end
      abte_pkg::OP_TST_LOW: begin
        res_out.skip = !bit_val;
      end
      abte_pkg::OP_TST_HIGH: begin
        res_out.skip = bit_val;
      end
      default: begin
        res_out = '0;
      end
    endcase
  end

endmodule : abte_alu

`default_nettype wire

// ==== tb/abte_testbench.sv ====
// Self-checking bench for the add and bit-test execute core
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [abte_pkg::ADR_W-1:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] w_val;
  logic skip;
  int n_errors = 0;
  int checked = 0;
  logic [3:0] sel_req = 4'hf;

  always #4 clk = ~clk;

  abte_core dut_u (
    .CLOCK_IN(clk),
    .ARST_N_IN(arst_n),
    .WB_CYC_IN(cyc),
    .WB_STB_IN(stb),
    .WB_WE_IN(we),
    .WB_ADR_IN(adr),
    .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack),
    .W_OUT(w_val),
    .SKIP_OUT(skip)
  );

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // Request stands until ack is sampled high; read data is taken at that same edge
  task automatic wb_xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= sel_req;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("unexpected ack timeout: expected 1, seen %b", ack);
      end_sim();
    end else begin
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask : wb_xfer

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0000_0000, q);
    chk(name, exp, q);
  endtask : rd_chk

  task automatic run(input logic [13:0] ins);
    wr(abte_pkg::ADR_INSTR, {18'h0_0000, ins});
  endtask : run

  function automatic logic [9:0] fadr(input logic [6:0] f);
    return abte_pkg::ADR_FILE_BASE | {1'b0, f, 2'b00};
  endfunction : fadr

  // Expected status word after an add: bit0 carry, bit1 nibble carry, bit2 zero
  function automatic logic [31:0] add_stat(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {29'h0000_0000, s[7:0] == 8'h00, n[4], s[8]};
  endfunction : add_stat

  logic [7:0] aw[5] = '{8'h0f, 8'hff, 8'h80, 8'h12, 8'h00};
  logic [7:0] ak[5] = '{8'h01, 8'h01, 8'h80, 8'h34, 8'hff};
  logic [7:0] res;
  logic [31:0] c0;
  logic taken;
  logic [31:0] ex;
  logic [6:0] fa;

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("w after reset", 32'h0000_0000, {24'h00_0000, w_val});
    chk("skip after reset", 32'h0000_0000, {31'h0000_0000, skip});
    rd_chk("status after reset", abte_pkg::ADR_STAT, 32'h0000_0000);
    rd_chk("unmapped read", 10'h100, 32'h0000_0000);
    $display("test reset done");

    for (int i = 0; i < 5; i++) begin
      wr(abte_pkg::ADR_WREG, {24'h00_0000, aw[i]});
      wr(abte_pkg::ADR_STAT, 32'h0000_0000);
      run((i[0] ? 14'h3f00 : 14'h3e00) | {6'h00, ak[i]});
      chk("add immediate w", {24'h00_0000, aw[i] + ak[i]}, {24'h00_0000, w_val});
      rd_chk("add immediate flags", abte_pkg::ADR_STAT, add_stat(aw[i], ak[i]));
    end
    $display("test add immediate done");

    // Carry and nibble carry preset to one so that an AND visibly leaves them alone
    wr(abte_pkg::ADR_STAT, 32'h0000_0003);
    wr(abte_pkg::ADR_WREG, 32'h0000_00f0);
    run(14'h390f);
    chk("and immediate w", 32'h0000_0000, {24'h00_0000, w_val});
    rd_chk("and immediate flags", abte_pkg::ADR_STAT, 32'h0000_0007);
    run(14'h39ff);
    chk("and immediate full mask", 32'h0000_0000, {24'h00_0000, w_val});
    $display("test and immediate done");

    for (int d = 0; d < 2; d++) begin
      for (int op = 0; op < 2; op++) begin
        fa = d[0] ? 7'h7f : 7'h00;
        wr(abte_pkg::ADR_WREG, 32'h0000_009c);
        wr(fadr(fa), 32'h0000_006a);
        wr(abte_pkg::ADR_STAT, 32'h0000_0007);
        res = op[0] ? (8'h9c & 8'h6a) : (8'h9c + 8'h6a);
        ex = op[0] ? 32'h0000_0003 : add_stat(8'h9c, 8'h6a);
        run((op[0] ? 14'h0500 : 14'h0700) | {6'h00, d[0], fa});
        chk("file op w", {24'h00_0000, d[0] ? 8'h9c : res}, {24'h00_0000, w_val});
        rd_chk("file op file", fadr(fa), {24'h00_0000, d[0] ? res : 8'h6a});
        rd_chk("file op flags", abte_pkg::ADR_STAT, ex);
      end
    end
    $display("test file ops done");

    wr(abte_pkg::ADR_STAT, 32'h0000_0005);
    for (int b = 0; b < 8; b++) begin
      wr(fadr(7'h2a), 32'h0000_00ff);
      run(14'h1000 | {4'h0, b[2:0], 7'h2a});
      rd_chk("bit clear", fadr(7'h2a), {24'h00_0000, ~(8'h01 << b)});
      wr(fadr(7'h2a), 32'h0000_0000);
      run(14'h1400 | {4'h0, b[2:0], 7'h2a});
      rd_chk("bit set", fadr(7'h2a), {24'h00_0000, 8'h01 << b});
    end
    rd_chk("bit op flags", abte_pkg::ADR_STAT, 32'h0000_0005);
    $display("test bit clear and set done");

    for (int hi = 0; hi < 2; hi++) begin
      for (int bv = 0; bv < 2; bv++) begin
        taken = (bv[0] == hi[0]);
        wr(fadr(7'h11), {28'h000_0000, bv[0], 3'b000});
        wr(abte_pkg::ADR_WREG, 32'h0000_0010);
        wr(abte_pkg::ADR_STAT, 32'h0000_0005);
        wb_xfer(1'b0, abte_pkg::ADR_CYCLES, 32'h0000_0000, c0);
        run((hi[0] ? 14'h1c00 : 14'h1800) | {4'h0, 3'd3, 7'h11});
        chk("skip armed", {31'h0000_0000, taken}, {31'h0000_0000, skip});
        ex = {28'h000_0000, taken, 3'b101};
        rd_chk("status while armed", abte_pkg::ADR_STAT, ex);
        run(14'h3e01);
        ex = taken ? 32'h0000_0010 : 32'h0000_0011;
        chk("w after test", ex, {24'h00_0000, w_val});
        chk("skip cleared", 32'h0000_0000, {31'h0000_0000, skip});
        ex = taken ? 32'h0000_0000 : 32'h0000_3e01;
        rd_chk("last word", abte_pkg::ADR_INSTR, ex);
        ex = taken ? 32'h0000_0005 : 32'h0000_0000;
        rd_chk("flags after test", abte_pkg::ADR_STAT, ex);
        rd_chk("cycle count", abte_pkg::ADR_CYCLES, c0 + 32'h0000_0002);
      end
    end
    $display("test bit test skip done");

    // Narrow lanes, an unknown opcode, a read-only write and an unmapped write
    wr(abte_pkg::ADR_WREG, 32'h0000_0021);
    wb_xfer(1'b0, abte_pkg::ADR_CYCLES, 32'h0000_0000, c0);
    sel_req = 4'h1;
    run(14'h3e01);
    sel_req = 4'hf;
    chk("narrow instruction w", 32'h0000_0021, {24'h00_0000, w_val});
    run(14'h0000);
    chk("unknown opcode w", 32'h0000_0021, {24'h00_0000, w_val});
    wr(abte_pkg::ADR_CYCLES, 32'h0000_0000);
    wr(10'h100, 32'h0000_00ff);
    rd_chk("refused cycle count", abte_pkg::ADR_CYCLES, c0 + 32'h0000_0001);
    rd_chk("refused status", abte_pkg::ADR_STAT, 32'h0000_0005);
    $display("test refused requests done");
    end_sim();
  end

endmodule : testbench

`default_nettype wire
